// file: include/sram_host_defs.svh
// timing figures and derived cycle counts for the async sram host controller
`ifndef SRAM_HOST_DEFS_SVH
`define SRAM_HOST_DEFS_SVH

// reference clock period in ns (40 MHz)
`define SRAM_CLK_NS 25

// least time in ns rounded up to whole clock cycles, never below one
`define SRAM_CYC_UP(ns) ((((ns) + `SRAM_CLK_NS - 1) / `SRAM_CLK_NS) < 1 ? 1 : \
  (((ns) + `SRAM_CLK_NS - 1) / `SRAM_CLK_NS))

// read timing, fast grade / slow grade, ns
`define SRAM_ADDR_TO_VALID_FAST_NS 45
`define SRAM_ADDR_TO_VALID_SLOW_NS 55
`define SRAM_SELECT_TO_VALID_FAST_NS 45
`define SRAM_SELECT_TO_VALID_SLOW_NS 55
`define SRAM_GATE_TO_VALID_FAST_NS 22
`define SRAM_GATE_TO_VALID_SLOW_NS 25
`define SRAM_LANE_TO_VALID_FAST_NS 22
`define SRAM_LANE_TO_VALID_SLOW_NS 25
`define SRAM_READ_CYCLE_FAST_NS 45
`define SRAM_READ_CYCLE_SLOW_NS 55
`define SRAM_OUT_FLOAT_NS 18

// write timing, fast grade / slow grade, ns
`define SRAM_WRITE_CYCLE_FAST_NS 45
`define SRAM_WRITE_CYCLE_SLOW_NS 55
`define SRAM_SELECT_TO_END_FAST_NS 35
`define SRAM_SELECT_TO_END_SLOW_NS 45
`define SRAM_ADDR_TO_END_FAST_NS 35
`define SRAM_ADDR_TO_END_SLOW_NS 45
`define SRAM_LANE_TO_END_FAST_NS 35
`define SRAM_LANE_TO_END_SLOW_NS 45
`define SRAM_STROBE_PULSE_MIN_FAST_NS 35
`define SRAM_STROBE_PULSE_MIN_SLOW_NS 40
`define SRAM_WDATA_SETUP_NS 25
`define SRAM_STROBE_TO_FLOAT_FAST_NS 18
`define SRAM_STROBE_TO_FLOAT_SLOW_NS 20

// bit positions of the two byte lanes in the request lane mask
`define SRAM_LANE_LOWER 0
`define SRAM_LANE_UPPER 1

`endif

// file: include/sram_host_pkg.sv
// types shared by the async sram host controller
package sram_host_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_ACCESS,
    ST_RD_RECOVER,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_HOLD
  } host_state_e;

endpackage

// file: core/cycle_timer.sv
// loadable down-counter that times phases of an sram access
`timescale 1ns/1ps
module cycle_timer #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic done
);

  logic [WIDTH-1:0] count;

  // load wins over counting; holds at zero once expired
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count <= '0;
    end
    else if (clk_en)
    begin
      if (load)
      begin
        count <= load_value;
      end
      else if (count != '0)
      begin
        count <= count - 1'b1;
      end
    end
  end

  assign done = (count == '0);

endmodule

// file: core/sram_host_ctrl.sv
// host controller driving an asynchronous 256k x 16 sram with error flag
`timescale 1ns/1ps
`include "sram_host_defs.svh"
module sram_host_ctrl
  import sram_host_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 16,
  parameter bit SLOW_GRADE = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic rsp_err,
  output logic [ADDR_W-1:0] mem_addr,
  output logic primary_select_n,
  output logic secondary_select,
  output logic write_strobe_n,
  output logic output_gate_n,
  output logic upper_lane_enable_n,
  output logic lower_lane_enable_n,
  output logic [DATA_W-1:0] mem_data_out,
  output logic mem_data_oe_n,
  input wire logic [DATA_W-1:0] mem_data_in,
  input wire logic mem_err_in
);

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // read wait: the latest of address, select, gate and lane to valid
  localparam int RD_NS_FAST = max2(max2(`SRAM_ADDR_TO_VALID_FAST_NS,
    `SRAM_SELECT_TO_VALID_FAST_NS), max2(`SRAM_GATE_TO_VALID_FAST_NS,
    `SRAM_LANE_TO_VALID_FAST_NS));
  localparam int RD_NS_SLOW = max2(max2(`SRAM_ADDR_TO_VALID_SLOW_NS,
    `SRAM_SELECT_TO_VALID_SLOW_NS), max2(`SRAM_GATE_TO_VALID_SLOW_NS,
    `SRAM_LANE_TO_VALID_SLOW_NS));
  // pins stay asserted for the cycle time as well, so one wait covers both
  localparam int RD_CYC = SLOW_GRADE ?
    `SRAM_CYC_UP(max2(RD_NS_SLOW, `SRAM_READ_CYCLE_SLOW_NS)) :
    `SRAM_CYC_UP(max2(RD_NS_FAST, `SRAM_READ_CYCLE_FAST_NS));

  // strobe low time covers pulse, select, address and lane figures to end;
  // the gate stays high during writes, so setup plus float is not the bound
  localparam int WR_NS_FAST = max2(max2(`SRAM_STROBE_PULSE_MIN_FAST_NS,
    `SRAM_SELECT_TO_END_FAST_NS), max2(max2(`SRAM_ADDR_TO_END_FAST_NS,
    `SRAM_LANE_TO_END_FAST_NS), `SRAM_WDATA_SETUP_NS));
  localparam int WR_NS_SLOW = max2(max2(`SRAM_STROBE_PULSE_MIN_SLOW_NS,
    `SRAM_SELECT_TO_END_SLOW_NS), max2(max2(`SRAM_ADDR_TO_END_SLOW_NS,
    `SRAM_LANE_TO_END_SLOW_NS), `SRAM_WDATA_SETUP_NS));
  localparam int WR_CYC = SLOW_GRADE ? `SRAM_CYC_UP(WR_NS_SLOW) :
    `SRAM_CYC_UP(WR_NS_FAST);
  // setup cycle plus pulse must reach the write cycle time
  localparam int WC_CYC = SLOW_GRADE ? `SRAM_CYC_UP(`SRAM_WRITE_CYCLE_SLOW_NS) :
    `SRAM_CYC_UP(`SRAM_WRITE_CYCLE_FAST_NS);
  localparam int WR_PULSE_CYC = max2(WR_CYC, WC_CYC - 1);
  // bus turnaround after a read: device float time fits in these cycles
  localparam int FLOAT_CYC = `SRAM_CYC_UP(`SRAM_OUT_FLOAT_NS);

  localparam int TW = 4;
  // the lane pins split the bus into two bytes; every phase must fit the timer
  if (DATA_W != 16 || ADDR_W < 1 || ADDR_W > 18 || RD_CYC > 15 || WR_PULSE_CYC > 15 ||
    FLOAT_CYC > 15)
  begin : g_bad_params
    $error("sram_host_ctrl: need DATA_W 16, ADDR_W 1 to 18, phases under 16 cycles");
  end

  host_state_e state;
  logic timer_load;
  logic [TW-1:0] timer_value;
  logic timer_done;
  logic [1:0] lanes_held;

  cycle_timer #(
    .WIDTH(TW)
  ) phase_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .load(timer_load),
    .load_value(timer_value),
    .done(timer_done)
  );

  // timer is loaded on entry to each timed phase (read access, read recover, write pulse) with its length minus one;
  // the value is a don't-care whenever load is low
  assign timer_load = (state == ST_IDLE && req_valid && !req_write) ||
    (state == ST_RD_ACCESS && timer_done) || state == ST_WR_SETUP;
  assign timer_value = (state == ST_IDLE) ? TW'(RD_CYC - 1) :
    (state == ST_RD_ACCESS) ? TW'(FLOAT_CYC - 1) :
    TW'(WR_PULSE_CYC - 1);

  // access sequencer; a request is taken only while idle and ready
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
    end
    else if (clk_en)
    begin
      case (state)
        ST_IDLE:
        begin
          if (req_valid && req_ready)
          begin
            state <= req_write ? ST_WR_SETUP : ST_RD_ACCESS;
          end
        end
        ST_RD_ACCESS:
        begin
          if (timer_done)
          begin
            state <= ST_RD_RECOVER;
          end
        end
        ST_RD_RECOVER:
        begin
          if (timer_done)
          begin
            state <= ST_IDLE;
          end
        end
        ST_WR_SETUP:
        begin
          state <= ST_WR_PULSE;
        end
        ST_WR_PULSE:
        begin
          if (timer_done)
          begin
            state <= ST_WR_HOLD;
          end
        end
        ST_WR_HOLD:
        begin
          state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ready is low from the accepting edge until the sequencer is idle again
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_ready <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state == ST_IDLE && req_valid && req_ready)
      begin
        req_ready <= 1'b0;
      end
      else if (state == ST_IDLE || state == ST_WR_HOLD ||
        (state == ST_RD_RECOVER && timer_done))
      begin
        req_ready <= 1'b1;
      end
    end
  end

  // address, data and lanes are latched once and held through the access
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem_addr <= '0;
      mem_data_out <= '0;
      lanes_held <= 2'h0;
    end
    else if (clk_en && state == ST_IDLE && req_valid && req_ready)
    begin
      mem_addr <= req_addr;
      mem_data_out <= req_wdata;
      lanes_held <= req_lanes;
    end
  end

  // memory pins: selects, lanes and our data driver go active with the address
  // and drop one cycle after the strobe rises, so the strobe edge alone ends
  // every write; the gate stays high in writes so the memory never drives
  // against our write data
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      primary_select_n <= 1'b1;
      secondary_select <= 1'b0;
      upper_lane_enable_n <= 1'b1;
      lower_lane_enable_n <= 1'b1;
      output_gate_n <= 1'b1;
      write_strobe_n <= 1'b1;
      mem_data_oe_n <= 1'b1;
    end
    else if (clk_en)
    begin
      if (state == ST_IDLE && req_valid && req_ready)
      begin
        primary_select_n <= 1'b0;
        secondary_select <= 1'b1;
        upper_lane_enable_n <= !req_lanes[`SRAM_LANE_UPPER];
        lower_lane_enable_n <= !req_lanes[`SRAM_LANE_LOWER];
        output_gate_n <= req_write; // low only for reads
        mem_data_oe_n <= !req_write;
      end
      else if (state == ST_WR_SETUP)
      begin
        write_strobe_n <= 1'b0;
      end
      else if (state == ST_WR_PULSE && timer_done)
      begin
        write_strobe_n <= 1'b1;
      end
      else if ((state == ST_RD_ACCESS && timer_done) || state == ST_WR_HOLD)
      begin
        primary_select_n <= 1'b1;
        secondary_select <= 1'b0;
        upper_lane_enable_n <= 1'b1;
        lower_lane_enable_n <= 1'b1;
        output_gate_n <= 1'b1;
        mem_data_oe_n <= 1'b1;
      end
    end
  end

  // read capture at the end of the access wait; disabled lanes read zero
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      rsp_err <= 1'b0;
    end
    else if (clk_en)
    begin
      rsp_valid <= (state == ST_RD_ACCESS) && timer_done;
      if (state == ST_RD_ACCESS && timer_done)
      begin
        rsp_rdata <= mem_data_in & {{8{lanes_held[`SRAM_LANE_UPPER]}},
          {8{lanes_held[`SRAM_LANE_LOWER]}}};
        rsp_err <= mem_err_in;
      end
    end
  end

endmodule

// file: verification/sram_host_props.sv
// pin-level assertions for the async sram host controller
`timescale 1ns/1ps
module sram_host_props #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic primary_select_n,
  input wire logic secondary_select,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic upper_lane_enable_n,
  input wire logic lower_lane_enable_n,
  input wire logic [DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // selected only with both selects active
  wire sel = !primary_select_n && secondary_select;
  wire [1:0] lanes_n = {upper_lane_enable_n, lower_lane_enable_n};

  // two low cycles give 50 ns, above either grade's minimum
  property p_strobe_pulse;
    $fell(write_strobe_n) |-> !write_strobe_n [*2] ##1 write_strobe_n;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("strobe pulse width wrong");
  property p_sel_in_write;
    !write_strobe_n |-> sel && output_gate_n;
  endproperty
  a_sel_in_write: assert property (p_sel_in_write)
    else $error("strobe low without select or with gate low");
  property p_write_end;
    $rose(write_strobe_n) |-> $past(sel, 3) && $stable(mem_addr) && $stable(mem_data_out)
      && !mem_data_oe_n;
  endproperty
  a_write_end: assert property (p_write_end)
    else $error("setup or hold broken at write end");
  property p_hold_in_write;
    !write_strobe_n |-> $stable(mem_addr) && $stable(lanes_n);
  endproperty
  a_hold_in_write: assert property (p_hold_in_write)
    else $error("address or lanes moved during write");
  property p_no_clash;
    !output_gate_n |-> mem_data_oe_n && write_strobe_n;
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("bus driven while gate low");
  property p_read_span;
    $fell(output_gate_n) |-> (sel && !output_gate_n) [*2] ##1 (!sel && output_gate_n && rsp_valid);
  endproperty
  a_read_span: assert property (p_read_span)
    else $error("read access window wrong");
  property p_ready_space;
    $fell(primary_select_n) |-> !req_ready [*3];
  endproperty
  a_ready_space: assert property (p_ready_space)
    else $error("access spacing too short");
  property p_release;
    $rose(mem_data_oe_n) |-> $past(write_strobe_n) && !$past(write_strobe_n, 2);
  endproperty
  a_release: assert property (p_release)
    else $error("data released at wrong time");
  c_read: cover property ($rose(rsp_valid));
  c_err: cover property (rsp_valid && rsp_err);
  c_write: cover property ($rose(write_strobe_n));
endmodule

bind sram_host_ctrl sram_host_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) sram_host_props_inst (
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .req_ready(req_ready),
  .rsp_valid(rsp_valid),
  .rsp_err(rsp_err),
  .mem_addr(mem_addr),
  .primary_select_n(primary_select_n),
  .secondary_select(secondary_select),
  .write_strobe_n(write_strobe_n),
  .output_gate_n(output_gate_n),
  .upper_lane_enable_n(upper_lane_enable_n),
  .lower_lane_enable_n(lower_lane_enable_n),
  .mem_data_out(mem_data_out),
  .mem_data_oe_n(mem_data_oe_n)
);

// file: verification/sram_device_model.sv
// behavioural model of the asynchronous sram with error flag
`timescale 1ns/1ps
module sram_device_model (
  input wire logic [17:0] mem_addr,
  input wire logic primary_select_n,
  input wire logic secondary_select,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic upper_lane_enable_n,
  input wire logic lower_lane_enable_n,
  input wire logic [15:0] mem_data_out,
  input wire logic mem_data_oe_n,
  input wire logic slow,
  input wire logic [17:0] err_addr,
  output logic [15:0] mem_data_in,
  output logic mem_err_in
);
  logic [15:0] mem [256];
  logic [15:0] q = 16'h5a5a;
  logic e = 1'b0;
  // no power state: selection acts at once
  wire sel = !primary_select_n && secondary_select;
  wire rd = sel && write_strobe_n && !output_gate_n;
  wire wr = sel && !write_strobe_n && !(upper_lane_enable_n && lower_lane_enable_n);
  // old value kept 10 ns, then junk; float beats drive so no clash
  always @(mem_addr, rd, upper_lane_enable_n, lower_lane_enable_n, err_addr)
  begin
    q <= #10 ~q;
    e <= #10 ~e;
    if (rd)
    begin
      q[15:8] <= #(slow ? 44 : 12) mem[mem_addr[7:0]][15:8];
      q[7:0] <= #(slow ? 44 : 12) mem[mem_addr[7:0]][7:0];
      e <= #(slow ? 44 : 12) (mem_addr == err_addr);
    end
  end
  // store at the end of the overlap; assumes lanes are still on then
  always @(negedge wr)
  begin
    if (!lower_lane_enable_n)
      mem[mem_addr[7:0]][7:0] = mem_data_in[7:0];
    if (!upper_lane_enable_n)
      mem[mem_addr[7:0]][15:8] = mem_data_in[15:8];
  end
  // bus level: the controller's own drive wins
  assign mem_data_in = mem_data_oe_n ? q : mem_data_out;
  assign mem_err_in = e;
endmodule

// file: verification/sram_host_ctrl_test.sv
// self-checking bench for the async sram host controller
`timescale 1ns/1ps
module sram_host_ctrl_test;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [17:0] req_addr = 18'h0;
  logic [15:0] req_wdata = 16'h0;
  logic [1:0] req_lanes = 2'h0;
  logic slow = 1'b0;
  logic [17:0] err_addr = 18'h00077;
  logic req_ready, rsp_valid, rsp_err, rd_err;
  logic [15:0] rsp_rdata, mem_data_out, mem_data_in, rd_data;
  logic [17:0] mem_addr;
  logic primary_select_n, secondary_select, write_strobe_n, output_gate_n;
  logic upper_lane_enable_n, lower_lane_enable_n, mem_data_oe_n, mem_err_in;
  int bad_count = 0;
  int checks_done = 0;

  // 40 MHz reference clock
  always #12.5 ref_clk = ~ref_clk;

  sram_host_ctrl sram_host_ctrl_inst (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .req_valid(req_valid),
    .req_write(req_write),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .req_lanes(req_lanes),
    .req_ready(req_ready),
    .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata),
    .rsp_err(rsp_err),
    .mem_addr(mem_addr),
    .primary_select_n(primary_select_n),
    .secondary_select(secondary_select),
    .write_strobe_n(write_strobe_n),
    .output_gate_n(output_gate_n),
    .upper_lane_enable_n(upper_lane_enable_n),
    .lower_lane_enable_n(lower_lane_enable_n),
    .mem_data_out(mem_data_out),
    .mem_data_oe_n(mem_data_oe_n),
    .mem_data_in(mem_data_in),
    .mem_err_in(mem_err_in)
  );
  sram_device_model sram_device_model_inst (
    .mem_addr(mem_addr),
    .primary_select_n(primary_select_n),
    .secondary_select(secondary_select),
    .write_strobe_n(write_strobe_n),
    .output_gate_n(output_gate_n),
    .upper_lane_enable_n(upper_lane_enable_n),
    .lower_lane_enable_n(lower_lane_enable_n),
    .mem_data_out(mem_data_out),
    .mem_data_oe_n(mem_data_oe_n),
    .slow(slow),
    .err_addr(err_addr),
    .mem_data_in(mem_data_in),
    .mem_err_in(mem_err_in)
  );

  // compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // one request held until taken; reads wait for the answer
  task automatic do_op(input logic w, input logic [17:0] a, input logic [15:0] d,
                       input logic [1:0] l);
    int n;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_lanes <= l;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 40);
    req_valid <= 1'b0;
    check(16'(n < 40), 16'h1, "request not taken");
    while (!w && rsp_valid !== 1'b1 && n < 80)
    begin
      @(posedge ref_clk);
      n++;
    end
    check(16'(n < 80), 16'h1, "no answer");
    rd_data = rsp_rdata;
    rd_err = rsp_err;
  endtask

  task automatic t_read(input logic [17:0] a, input logic [1:0] l, input logic [15:0] d,
                        input logic er);
    do_op(1'b0, a, 16'h0, l);
    check(rd_data, d, "read data");
    check(16'(rd_err), 16'(er), "error flag");
  endtask

  // pins idle while reset is held
  task automatic t_reset();
    check(16'({req_ready, rsp_valid, primary_select_n, secondary_select,
      write_strobe_n, output_gate_n, mem_data_oe_n, upper_lane_enable_n,
      lower_lane_enable_n}), 16'h005f, "idle pins");
  endtask

  // frozen clock enable keeps a pending request untaken
  task automatic t_freeze();
    @(posedge ref_clk);
    clk_en <= 1'b0;
    req_valid <= 1'b1;
    req_write <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check(16'(primary_select_n), 16'h1, "frozen select");
    clk_en <= 1'b1;
    req_valid <= 1'b0;
  endtask

  task automatic finish_test();
    $display("mismatches %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // main sequence: full, byte-lane, empty-lane, slow and error-flag accesses
  initial
  begin
    repeat (12) @(posedge ref_clk);
    t_reset();
    rst_b <= 1'b1;
    do_op(1'b1, 18'h00012, 16'ha5c3, 2'h3);
    t_read(18'h00012, 2'h3, 16'ha5c3, 1'b0);
    do_op(1'b1, 18'h00012, 16'h1111, 2'h1);
    do_op(1'b1, 18'h00012, 16'h2222, 2'h2);
    t_read(18'h00012, 2'h3, 16'h2211, 1'b0);
    t_read(18'h00012, 2'h1, 16'h0011, 1'b0);
    do_op(1'b1, 18'h00012, 16'hffff, 2'h0);
    t_read(18'h00012, 2'h3, 16'h2211, 1'b0);
    do_op(1'b1, 18'h00077, 16'h0f0f, 2'h3);
    slow <= 1'b1;
    t_read(18'h00077, 2'h3, 16'h0f0f, 1'b1);
    t_read(18'h00012, 2'h2, 16'h2200, 1'b0);
    slow <= 1'b0;
    t_freeze();
    t_read(18'h00012, 2'h3, 16'h2211, 1'b0);
    finish_test();
  end

  // watchdog, far beyond the hundred or so cycles the tests need
  initial
  begin
    #50000;
    bad_count++;
    finish_test();
  end
endmodule
